// [shared/tcu_defines.svh]
// register map, field positions, codes and reset values of the timer unit
`ifndef TCU_DEFINES_SVH
`define TCU_DEFINES_SVH

// register offsets on the plain register port
`define TCU_ADDR_W 3
`define TCU_OFS_CTRL 3'h0
`define TCU_OFS_CMP 3'h1
`define TCU_OFS_DUTY 3'h2
`define TCU_OFS_CNT 3'h3
`define TCU_OFS_CFG 3'h4

// unit control register fields
`define TCU_BIT_FFINIT 7
`define TCU_SRC_HI 6
`define TCU_SRC_LO 4
`define TCU_BIT_RUN 3
`define TCU_MODE_HI 2
`define TCU_MODE_LO 0

// configuration register fields
`define TCU_BIT_DIVSEL 0

// mode select codes
`define TCU_MODE_TIMER 3'h0
`define TCU_MODE_DIV 3'h1
`define TCU_MODE_PWM 3'h2

// source clock select codes
`define TCU_SRC_EVENT 3'h7

// prescaler tap exponents for select codes 0 to 3
`define TCU_TAP_EXP0 4'hB
`define TCU_TAP_EXP1 4'h7
`define TCU_TAP_EXP2 4'h5
`define TCU_TAP_EXP3 4'h3
`define TCU_PRESC_W 13

// counter limits and reset values
`define TCU_CNT_ZERO 8'h00
`define TCU_CNT_ONE 8'h01
`define TCU_CNT_MAX 8'hFF
`define TCU_RST_BYTE 8'h00
`define TCU_RST_MODE 3'h0
`define TCU_RST_SRC 3'h0
`define TCU_RST_FF 1'b0

`endif

// [shared/tcu_pkg.sv]
// types shared by the timer unit modules
package tcu_pkg;

  typedef logic [7:0] tcu_byte_type;

  // state of one timer unit, apart from its prescaler and event synchroniser
  typedef struct packed {
    logic ffinit;
    logic [2:0] src;
    logic run;
    logic [2:0] mode;
    logic divsel;
    tcu_byte_type cmp;
    tcu_byte_type duty_act;
    tcu_byte_type duty_buf;
    tcu_byte_type cnt;
    tcu_byte_type rdata;
    logic tff;
    logic irq;
    logic div_pin;
    logic mod_pin;
  } tcu_state_type;

  // event pin synchroniser state
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic fall;
  } tcu_sync_type;

endpackage : tcu_pkg

// [hw/tcu_edge_sync.sv]
// two-flop synchroniser and falling edge pulse for the event input pin
`timescale 1ns/1ps
`include "tcu_defines.svh"

module tcu_edge_sync
  import tcu_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_pin,
  output logic o_fall
);

  tcu_sync_type st_r;
  tcu_sync_type st_nxt;

  // only the second flop and later stages feed the edge detector
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = i_pin;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
    st_nxt.fall = st_r.prev & ~st_r.sync;
  end

  // idle high so reset release gives no false edge
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_r <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1, fall: 1'b0};
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_fall = st_r.fall;

endmodule : tcu_edge_sync

// [hw/tcu_prescaler.sv]
// free-running prescaler with one selectable power-of-two tap pulse
`timescale 1ns/1ps
`include "tcu_defines.svh"

module tcu_prescaler
  import tcu_pkg::*;
#(
  parameter int WIDTH = `TCU_PRESC_W
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [1:0] i_sel,
  input wire logic i_divsel,
  output logic o_tick
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic tick;
  } tcu_presc_type;

  tcu_presc_type st_r;
  tcu_presc_type st_nxt;
  logic [3:0] tap_exp;
  logic [WIDTH-1:0] tap_mask;

  // [R5] tap selection, halved by divide select
  always_comb begin
    case (i_sel)
      2'h0: tap_exp = `TCU_TAP_EXP0;
      2'h1: tap_exp = `TCU_TAP_EXP1;
      2'h2: tap_exp = `TCU_TAP_EXP2;
      default: tap_exp = `TCU_TAP_EXP3;
    endcase
    tap_exp = tap_exp + {3'h0, i_divsel};
    tap_mask = ~({WIDTH{1'b1}} << tap_exp);
    st_nxt.cnt = st_r.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
    st_nxt.tick = ((st_r.cnt & tap_mask) == tap_mask);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_tick = st_r.tick;

endmodule : tcu_prescaler

// [hw/tcu_timer.sv]
// one 8-bit timer/counter unit: timer, event, divider and pwm modes
`timescale 1ns/1ps
`include "tcu_defines.svh"

// How it works
// [R1] Timer mode counts prescaler ticks; match raises interrupt, clears, continues.
// [R2] Compare register is unbuffered outside pwm; writes act immediately.
// [R3] Software leaves compare register alone while the counter runs.
// [R4] Software keeps initial value bit zero in timer and event modes.
// [R5] Source is one of four prescaler taps, each halved by divide select.
// [R6] Event mode counts event pin falling edges; match interrupts and clears.
// [R7] Event pin levels last two machine cycles; rate at most fc/16.
// [R8] Divider mode toggles flip-flop, clears and interrupts on each match.
// [R9] Divider output pin drives inverse of toggle flip-flop.
// [R10] Writing the initial value bit loads the flip-flop; reset clears it.
// [R11] Software sets the shared port output latch to one first.
// [R12] Stopped counter leaves output pins at their level until reload.
// [R13] Software stops first, then writes initial value bit separately.
// [R14] Pwm toggles on duty match, toggles again on overflow with interrupt.
// [R15] Modulated output pin drives inverse of toggle flip-flop.
// [R16] Pwm duty writes buffer while running, transfer at overflow or at once.
// [R17] Duty reads return active value until the overflow transfer.
// [R18] Software writes duty right after the overflow interrupt.
// [R19] Software stops the counter before entering stop power mode.
// [R20] Control bit 3 is run control, bit 7 initial value bit.
// [R21] Mode codes: 000 timer/event, 001 divider, 010 pwm; others idle.
// [R22] Run bit 0 stops; 1 starts from a cleared counter.
// [R23] Interrupt is one pulse per match or overflow.
module tcu_timer
  import tcu_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [`TCU_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_event_input_pin,
  output logic [7:0] o_rdata,
  output logic o_match_interrupt,
  output logic o_divider_output_pin,
  output logic o_modulated_output_pin
);

  tcu_state_type state_r;
  tcu_state_type state_nxt;

  // tick sources
  logic presc_tick;
  logic event_fall;
  logic src_tick;

  // decoded helpers
  logic wr_ctrl;
  logic wr_cmp;
  logic wr_duty;
  logic wr_cfg;
  logic run_new;
  logic starting;
  logic stopping;
  logic pwm_running;
  logic count_en;
  tcu_byte_type cnt_inc;
  logic cmp_hit;
  logic duty_hit;
  logic overflow;

  // prescaler taps follow the stored select and divide bit
  tcu_prescaler #(
    .WIDTH(`TCU_PRESC_W)
  ) u_presc (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_sel(state_r.src[1:0]),
    .i_divsel(state_r.divsel),
    .o_tick(presc_tick)
  );

  // the pin is asynchronous, so it is synchronised before edge detection
  tcu_edge_sync u_evsync (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_pin(i_event_input_pin),
    .o_fall(event_fall)
  );

  // source select: internal tap codes, event pin code, others never tick
  always_comb begin
    if (state_r.src == `TCU_SRC_EVENT) begin
      // [R6] falling edge counting
      src_tick = event_fall;
    end else if (!state_r.src[2]) begin
      // [R5] internal prescaler tap
      src_tick = presc_tick;
    end else begin
      src_tick = 1'b0;
    end
  end

  // write decode and run transitions
  always_comb begin
    wr_ctrl = i_wr && (i_addr == `TCU_OFS_CTRL);
    wr_cmp = i_wr && (i_addr == `TCU_OFS_CMP);
    wr_duty = i_wr && (i_addr == `TCU_OFS_DUTY);
    wr_cfg = i_wr && (i_addr == `TCU_OFS_CFG);
    run_new = i_wdata[`TCU_BIT_RUN];
    starting = wr_ctrl && run_new && !state_r.run;
    stopping = wr_ctrl && !run_new && state_r.run;
    pwm_running = state_r.run && (state_r.mode == `TCU_MODE_PWM);
  end

  // counter arithmetic; compares see the live registers
  always_comb begin
    cnt_inc = state_r.cnt + `TCU_CNT_ONE;
    // [R2] compare uses the register as just written
    cmp_hit = (cnt_inc == state_r.cmp);
    duty_hit = (cnt_inc == state_r.duty_act);
    overflow = (state_r.cnt == `TCU_CNT_MAX);
    // a control write takes the cycle, so its tick is dropped
    count_en = state_r.run && src_tick && !wr_ctrl;
  end

  // next-state logic: register writes first, then counting, then reads
  always_comb begin
    state_nxt = state_r;
    state_nxt.irq = 1'b0;
    state_nxt.rdata = `TCU_RST_BYTE;

    // control register write
    if (wr_ctrl) begin
      state_nxt.mode = i_wdata[`TCU_MODE_HI:`TCU_MODE_LO];
      state_nxt.src = i_wdata[`TCU_SRC_HI:`TCU_SRC_LO];
      state_nxt.ffinit = i_wdata[`TCU_BIT_FFINIT];
      // [R20] bit 3 runs or stops the counter
      state_nxt.run = run_new;
      // [R12] a stopping write leaves the flip-flop as it was
      if (!stopping) begin
        // [R10] initial value bit loads the flip-flop
        state_nxt.tff = i_wdata[`TCU_BIT_FFINIT];
      end
      if (starting) begin
        // [R22] start from a cleared counter
        state_nxt.cnt = `TCU_CNT_ZERO;
      end
    end

    // compare register write, no shadow copy
    if (wr_cmp) begin
      // [R2] takes effect on the next compare
      state_nxt.cmp = i_wdata;
    end

    // duty register write
    if (wr_duty) begin
      state_nxt.duty_buf = i_wdata;
      if (!pwm_running) begin
        // [R16] stopped or other mode: transfer at once
        state_nxt.duty_act = i_wdata;
      end
    end

    // configuration register write
    if (wr_cfg) begin
      state_nxt.divsel = i_wdata[`TCU_BIT_DIVSEL];
    end

    // counting on each source tick while running, except in a control write cycle
    if (count_en) begin
      case (state_r.mode)
        `TCU_MODE_TIMER: begin
          // [R1] match clears and keeps counting
          if (cmp_hit) begin
            state_nxt.cnt = `TCU_CNT_ZERO;
            // [R23] one pulse per match
            state_nxt.irq = 1'b1;
          end else begin
            state_nxt.cnt = cnt_inc;
          end
        end
        `TCU_MODE_DIV: begin
          // [R8] match toggles, clears, interrupts
          if (cmp_hit) begin
            state_nxt.cnt = `TCU_CNT_ZERO;
            state_nxt.tff = ~state_r.tff;
            state_nxt.irq = 1'b1;
          end else begin
            state_nxt.cnt = cnt_inc;
          end
        end
        `TCU_MODE_PWM: begin
          // [R14] overflow toggles, clears, interrupts
          if (overflow) begin
            state_nxt.cnt = `TCU_CNT_ZERO;
            state_nxt.tff = ~state_r.tff;
            state_nxt.irq = 1'b1;
            // [R16] buffered duty moves over on the overflow
            // a coinciding write hands over its new value directly
            if (wr_duty) begin
              state_nxt.duty_act = i_wdata;
            end else begin
              state_nxt.duty_act = state_r.duty_buf;
            end
          end else begin
            state_nxt.cnt = cnt_inc;
            // [R14] duty match toggles and counting continues
            if (duty_hit) begin
              state_nxt.tff = ~state_r.tff;
            end
          end
        end
        default: begin
          // [R21] cascaded and warm-up codes are not served here
          state_nxt.cnt = state_r.cnt;
        end
      endcase
    end

    // read data, valid only in the cycle after the strobe
    if (i_rd) begin
      case (i_addr)
        `TCU_OFS_CTRL: begin
          state_nxt.rdata = {state_r.ffinit, state_r.src, state_r.run,
                             state_r.mode};
        end
        `TCU_OFS_CMP: begin
          state_nxt.rdata = state_r.cmp;
        end
        `TCU_OFS_DUTY: begin
          // [R17] the active value, not the pending buffer
          state_nxt.rdata = state_r.duty_act;
        end
        `TCU_OFS_CNT: begin
          state_nxt.rdata = state_r.cnt;
        end
        `TCU_OFS_CFG: begin
          state_nxt.rdata = {7'h00, state_r.divsel};
        end
        default: begin
          // unmapped offsets read as zero
          state_nxt.rdata = `TCU_RST_BYTE;
        end
      endcase
    end

    // pins follow the flip-flop of the same edge, so they stay flops
    // [R9] divider output is the inverted flip-flop
    state_nxt.div_pin = ~state_nxt.tff;
    // [R15] modulated output is the inverted flip-flop
    state_nxt.mod_pin = ~state_nxt.tff;
  end

  // single state register; clock enable low freezes everything
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_r.ffinit <= `TCU_RST_FF;
      state_r.src <= `TCU_RST_SRC;
      state_r.run <= 1'b0;
      state_r.mode <= `TCU_RST_MODE;
      state_r.divsel <= 1'b0;
      state_r.cmp <= `TCU_RST_BYTE;
      state_r.duty_act <= `TCU_RST_BYTE;
      state_r.duty_buf <= `TCU_RST_BYTE;
      state_r.cnt <= `TCU_CNT_ZERO;
      state_r.rdata <= `TCU_RST_BYTE;
      // [R10] reset clears the flip-flop, pins sit high
      state_r.tff <= `TCU_RST_FF;
      state_r.irq <= 1'b0;
      state_r.div_pin <= ~`TCU_RST_FF;
      state_r.mod_pin <= ~`TCU_RST_FF;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from the state register
  assign o_rdata = state_r.rdata;
  assign o_match_interrupt = state_r.irq;
  assign o_divider_output_pin = state_r.div_pin;
  assign o_modulated_output_pin = state_r.mod_pin;

endmodule : tcu_timer

// [dv/tcu_timer_props.sv]
// port assertions for one timer unit
`timescale 1ns/1ps
`include "tcu_defines.svh"

module tcu_timer_props
  import tcu_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [`TCU_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_event_input_pin,
  input wire logic [7:0] o_rdata,
  input wire logic o_match_interrupt,
  input wire logic o_divider_output_pin,
  input wire logic o_modulated_output_pin
);
  logic cw, run_r, val_r, divs_r;
  logic [2:0] mode_r, src_r;
  logic [7:0] cmp_r;
  int gap_r, ex, per;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  // control writes that land; strobes with clock enable low are lost
  assign cw = i_wr && i_ce && (i_addr == `TCU_OFS_CTRL);

  // shadow of the settings and interrupt spacing; any write voids the gap
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      run_r <= 1'b0;
      val_r <= 1'b0;
      divs_r <= 1'b0;
      mode_r <= 3'h0;
      src_r <= 3'h0;
      cmp_r <= 8'h00;
      gap_r <= 0;
    end else begin
      if (cw) begin
        run_r <= i_wdata[3];
        src_r <= i_wdata[6:4];
        mode_r <= i_wdata[2:0];
      end
      if (i_wr && i_ce && i_addr == `TCU_OFS_CMP) cmp_r <= i_wdata;
      if (i_wr && i_ce && i_addr == `TCU_OFS_CFG) divs_r <= i_wdata[0];
      gap_r <= o_match_interrupt ? 1 : gap_r + 1;
      val_r <= (i_wr || !i_ce) ? 1'b0 : (o_match_interrupt | val_r);
    end
  end

  // expected cycles between interrupts
  always_comb begin
    ex = (src_r[1:0] == 2'h0) ? 11 : 9 - 2 * int'(src_r[1:0]);
    per = ((mode_r == `TCU_MODE_PWM || cmp_r == 8'h00) ? 256 : int'(cmp_r))
      << (ex + int'(divs_r));
  end

  sequence s_stopped_quiet;
    (!run_r && !cw) [*2];
  endsequence

  a_pins_inverse: assert property (
    o_divider_output_pin == o_modulated_output_pin)
    else $error("output pins disagree");
  // a frozen clock enable holds the pulse, so only live cycles count
  a_irq_single: assert property (
    o_match_interrupt && i_ce |=> !o_match_interrupt)
    else $error("interrupt wider than one cycle");
  a_rdata_idle: assert property (!i_rd && i_ce |=> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_reset_pins: assert property (disable iff (1'b0)
    i_sys_rst |=> o_divider_output_pin && !o_match_interrupt)
    else $error("reset level wrong");
  a_stop_holds: assert property (
    s_stopped_quiet |=> $stable(o_divider_output_pin))
    else $error("pin moved while stopped");
  a_irq_needs_run: assert property (
    o_match_interrupt |-> run_r || $past(run_r) || $past(run_r, 2))
    else $error("interrupt while stopped");
  a_irq_period: assert property (
    o_match_interrupt && val_r && !src_r[2] && mode_r <= `TCU_MODE_PWM
    |-> gap_r == per)
    else $error("interrupt period wrong");
  a_div_toggles: assert property (
    o_match_interrupt && $past(i_ce) && run_r && mode_r == `TCU_MODE_DIV
    |-> o_divider_output_pin != $past(o_divider_output_pin))
    else $error("divider pin did not toggle");
endmodule : tcu_timer_props

// [dv/tcu_event_src.sv]
// event pulse source on the far side of the event input pin
`timescale 1ns/1ps

module tcu_event_src (
  input wire logic i_sys_clk,
  input wire logic i_en,
  input wire logic [7:0] i_half,
  output logic o_pin,
  output int o_falls
);
  int cnt = 0;

  // pin pulled high while idle
  initial begin
    o_pin = 1'b1;
    o_falls = 0;
  end

  // each level held eight clocks or more
  always @(posedge i_sys_clk) begin
    if (cnt + 1 < ((i_half < 8'h08) ? 8 : int'(i_half))) begin
      cnt <= cnt + 1;
    end else if (i_en || !o_pin) begin
      cnt <= 0;
      o_pin <= !o_pin;
      o_falls <= o_falls + (o_pin ? 1 : 0);
    end
  end
endmodule : tcu_event_src

// [dv/tb_tcu_timer.sv]
// self-checking bench for one timer unit
`timescale 1ns/1ps
`include "tcu_defines.svh"

module tb_tcu_timer
  import tcu_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_ce = 1'b1;
  logic [2:0] i_addr = 3'h0;
  tcu_byte_type i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic ev_en = 1'b0;
  logic [7:0] ev_half = 8'h08;
  logic i_event_input_pin, o_match_interrupt;
  logic o_divider_output_pin, o_modulated_output_pin;
  tcu_byte_type o_rdata, r;
  int fail_count = 0;
  int samples_checked = 0;
  int irqs = 0;
  int ev_falls, n, lo, c, d;

  always #10 i_sys_clk = ~i_sys_clk;

  tcu_timer tcu_timer_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_event_input_pin(i_event_input_pin), .o_rdata(o_rdata),
    .o_match_interrupt(o_match_interrupt),
    .o_divider_output_pin(o_divider_output_pin),
    .o_modulated_output_pin(o_modulated_output_pin));
  tcu_event_src tcu_event_src_i (.i_sys_clk(i_sys_clk), .i_en(ev_en),
    .i_half(ev_half), .o_pin(i_event_input_pin), .o_falls(ev_falls));

  // interrupt pulses seen so far
  always @(posedge i_sys_clk) if (o_match_interrupt === 1'b1) irqs <= irqs + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input tcu_byte_type v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output tcu_byte_type v);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  // next interrupt, then cycles and low pin cycles to the one after
  task automatic per(output int cyc, output int low);
    int k;
    k = 0;
    cyc = 0;
    low = 0;
    while (o_match_interrupt !== 1'b1 && k < 20000) begin
      @(posedge i_sys_clk);
      #1 k++;
    end
    do begin
      @(posedge i_sys_clk);
      #1 cyc++;
      if (o_divider_output_pin === 1'b0) low++;
    end while (o_match_interrupt !== 1'b1 && cyc < 20000);
  endtask : per

  // tap exponent for select codes 0 to 3
  function automatic int tap(input int s);
    return (s == 0) ? 11 : 9 - 2 * s;
  endfunction : tap

  task automatic conclude;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // watchdog well beyond the expected run
  initial begin
    #1800000;
    fail_count++;
    conclude();
  end

  initial begin
    void'($urandom(32'h1A5F));
    repeat (16) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    #1 chk(o_divider_output_pin, 1'b1);
    wr(3'h5, 8'hA5);
    for (int a = 0; a < 6; a++) begin
      rd(3'(a), r);
      chk(r, 8'h00);
    end
    d = 1 + $urandom % 255;
    wr(`TCU_OFS_CMP, 8'(d));
    rd(`TCU_OFS_CMP, r);
    chk(r, d);
    $display("test 1 done");
    // initial value bit kept low in timer mode
    for (int s = 0; s < 4; s++) begin
      for (int v = 0; v < 2; v++) begin
        c = 1 + $urandom % 3;
        wr(`TCU_OFS_CFG, 8'(v));
        wr(`TCU_OFS_CMP, 8'(c));
        wr(`TCU_OFS_CTRL, 8'(s << 4));
        wr(`TCU_OFS_CTRL, 8'((s << 4) | 8));
        per(n, lo);
        chk(n, c << (tap(s) + v));
        wr(`TCU_OFS_CTRL, 8'(s << 4));
      end
    end
    wr(`TCU_OFS_CFG, 8'h00);
    $display("test 2 done");
    ev_half <= 8'(8 + $urandom % 8);
    wr(`TCU_OFS_CMP, 8'h04);
    wr(`TCU_OFS_CTRL, 8'h78);
    rd(`TCU_OFS_CNT, r);
    chk(r, 8'h00);
    c = irqs;
    ev_en <= 1'b1;
    for (int k = 0; k < 400 && ev_falls < 10; k++) @(posedge i_sys_clk);
    ev_en <= 1'b0;
    repeat (40) @(posedge i_sys_clk);
    chk(irqs - c, 2);
    rd(`TCU_OFS_CNT, r);
    chk(r, 8'h02);
    $display("test 3 done");
    // stop the event count before the compare is rewritten
    wr(`TCU_OFS_CTRL, 8'h31);
    wr(`TCU_OFS_CMP, 8'h03);
    wr(`TCU_OFS_CTRL, 8'h39);
    per(n, lo);
    per(n, d);
    chk(n, 24);
    chk(lo + d, 24);
    // clock enable low freezes counter, prescaler and pins
    @(posedge i_sys_clk);
    i_ce <= 1'b0;
    #1 lo = irqs;
    c = o_divider_output_pin;
    repeat (36) @(posedge i_sys_clk);
    chk(irqs - lo, 0);
    chk(o_divider_output_pin, c);
    i_ce <= 1'b1;
    wr(`TCU_OFS_CTRL, 8'h31);
    #1 c = o_divider_output_pin;
    repeat (100) @(posedge i_sys_clk);
    chk(o_divider_output_pin, c);
    wr(`TCU_OFS_CTRL, 8'h81);
    #1 chk(o_modulated_output_pin, 1'b0);
    wr(`TCU_OFS_CTRL, 8'h01);
    #1 chk(o_divider_output_pin, 1'b1);
    $display("test 4 done");
    wr(`TCU_OFS_CTRL, 8'h32);
    wr(`TCU_OFS_DUTY, 8'h10);
    rd(`TCU_OFS_DUTY, r);
    chk(r, 8'h10);
    wr(`TCU_OFS_CTRL, 8'h3A);
    per(n, lo);
    chk(n, 2048);
    chk(lo, 1920);
    d = 2 + $urandom % 253;
    wr(`TCU_OFS_DUTY, 8'(d));
    rd(`TCU_OFS_DUTY, r);
    chk(r, 8'h10);
    per(n, lo);
    chk(lo, (256 - d) * 8);
    rd(`TCU_OFS_DUTY, r);
    chk(r, d);
    $display("test 5 done");
    // reset in mid-run, then reserved mode and idle source codes
    @(posedge i_sys_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    #1 chk(o_modulated_output_pin, 1'b1);
    rd(`TCU_OFS_DUTY, r);
    chk(r, 8'h00);
    c = irqs;
    wr(`TCU_OFS_CTRL, 8'h3B);
    repeat (40) @(posedge i_sys_clk);
    wr(`TCU_OFS_CTRL, 8'h48);
    repeat (40) @(posedge i_sys_clk);
    rd(`TCU_OFS_CNT, r);
    chk(r, 8'h00);
    chk(irqs - c, 0);
    wr(`TCU_OFS_CTRL, 8'h40);
    $display("test 6 done");
    conclude();
  end
endmodule : tb_tcu_timer

bind tcu_timer tcu_timer_props tcu_timer_props_i (.i_sys_clk(i_sys_clk),
  .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_event_input_pin(i_event_input_pin),
  .o_rdata(o_rdata), .o_match_interrupt(o_match_interrupt),
  .o_divider_output_pin(o_divider_output_pin),
  .o_modulated_output_pin(o_modulated_output_pin));
